// >>> hw/fhl_logger.sv
// Fault history logger: ten-deep code and stamp history plus a snapshot
`timescale 1ns/1ns
`include "fhl_consts.svh"
// How it works
// - Keeps ten newest fault codes, newest first
// - New fault enters newest, older shift down
// - Stored codes range zero through 999
// - Each slot stores day/month up to 31/12
// - Each slot stores year up to 2099
// - Each slot stores time up to 23:59
// - Captures armature current up to 5000.0 A
// - Captures armature voltage up to 2000 V
// - Captures motor speed up to 10000 rpm
// - Captures signed total reference within 10000 rpm
// - Captures field current up to 60.0 A
// - Latches eight digital inputs, bit0 first
// - Latches five digital outputs, bit0 first
// - All records are read only outputs
// - Stamps may be invalid near reset
module fhl_logger (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic fault_strobe, // One-cycle pulse per new fault
  input wire logic [9:0] fault_code_in,
  input wire logic [4:0] rtc_day,
  input wire logic [3:0] rtc_month,
  input wire logic [11:0] rtc_year,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_minute,
  input wire logic [15:0] armature_current_in, // Tenths of an ampere
  input wire logic [10:0] armature_voltage_in, // Volts
  input wire logic [13:0] speed_in, // rpm
  input wire logic signed [14:0] total_reference_in, // rpm
  input wire logic [9:0] field_current_in, // Tenths of an ampere
  input wire logic [7:0] digital_inputs_in,
  input wire logic [4:0] digital_outputs_in,
  input wire logic [3:0] read_slot, // 0 is newest, 9 oldest
  output logic [9:0] read_code,
  output logic [4:0] read_day,
  output logic [3:0] read_month,
  output logic [11:0] read_year,
  output logic [4:0] read_hour,
  output logic [5:0] read_minute,
  output logic [9:0] newest_fault_code,
  output logic [9:0] oldest_fault_code,
  output logic [8:0] newest_fault_day_month, // Day high, month low
  output logic [11:0] newest_fault_year,
  output logic [10:0] newest_fault_time, // Hour high, minute low
  output logic [15:0] fault_armature_current_snap,
  output logic [10:0] fault_armature_voltage_snap,
  output logic [13:0] fault_speed_snap,
  output logic signed [14:0] fault_total_reference_snap,
  output logic [9:0] fault_field_current_snap,
  output logic [7:0] fault_input_states_snap,
  output logic [4:0] fault_output_states_snap,
  output logic fault_recorded // Pulse one cycle after each capture
);

  // Incoming entry, before and after range clamping
  fhl_stamp_if stamp ();

  // History chain: slot_q[0] newest, slot_q[DEPTH-1] oldest
  fhl_pkg::fhl_entry_t slot_q [`FHL_DEPTH];
  fhl_pkg::fhl_entry_t slot_in [`FHL_DEPTH];

  // Capture sequencer state
  fhl_pkg::fhl_state_t state;
  fhl_pkg::fhl_state_t next_state;

  // Clamped snapshot values
  logic [15:0] next_ia;
  logic [10:0] next_va;
  logic [13:0] next_spd;
  logic signed [14:0] next_ref;
  logic [9:0] next_if;
  wire capture;
  wire [3:0] sel;
  fhl_pkg::fhl_entry_t sel_entry;

  // Raw entry from the fault source and the clock; no keypad path
  // reaches the history, so operator writes cannot alter it
  assign stamp.raw.code = fault_code_in;
  assign stamp.raw.day = rtc_day;
  assign stamp.raw.month = rtc_month;
  assign stamp.raw.year = rtc_year;
  assign stamp.raw.hour = rtc_hour;
  assign stamp.raw.minute = rtc_minute;

  fhl_clamp u_clamp (
    .st(stamp)
  );

  // Stamps are stored clamped but unchecked; a clock still settling after reset
  // may give a wrong stamp, which is accepted rather than blocked
  // since blocking would lose the fault code itself
  assign capture = fault_strobe;

  // Chain inputs: newest takes the clamped entry, others the neighbour
  assign slot_in[0] = stamp.clean;
  genvar g;
  generate
    for (g = 0; g < `FHL_DEPTH; g++) begin : g_slot
      if (g > 0) begin : g_link
        assign slot_in[g] = slot_q[g-1]; // Oldest falls off
      end
      fhl_slot u_slot (
        .ref_clk(ref_clk),
        .reset(reset),
        .shift(capture),
        .newer(slot_in[g]),
        .held(slot_q[g])
      );
    end
  endgenerate

  // Snapshot clamping, so each field stays within its range
  assign next_ia = (armature_current_in > `FHL_IA_MAX) ?
    `FHL_IA_MAX : armature_current_in;
  assign next_va = (armature_voltage_in > `FHL_VA_MAX) ?
    `FHL_VA_MAX : armature_voltage_in;
  assign next_spd = (speed_in > `FHL_SPD_MAX) ?
    `FHL_SPD_MAX : speed_in;
  assign next_ref = (total_reference_in > `FHL_REF_MAX) ? `FHL_REF_MAX :
    (total_reference_in < `FHL_REF_MIN) ? `FHL_REF_MIN :
    total_reference_in;
  assign next_if = (field_current_in > `FHL_IF_MAX) ?
    `FHL_IF_MAX : field_current_in;

  // Read selection; out-of-range index shows the oldest slot
  assign sel = (read_slot >= 4'(`FHL_DEPTH)) ?
    4'(`FHL_DEPTH - 1) : read_slot;
  assign sel_entry = slot_q[sel];

  // Sequencer marks the cycle after a capture
  always_comb begin
    next_state = fhl_pkg::FHL_IDLE;
    unique case (state)
      fhl_pkg::FHL_IDLE: begin
        next_state = capture ? fhl_pkg::FHL_HOLD : fhl_pkg::FHL_IDLE;
      end
      fhl_pkg::FHL_HOLD: begin
        next_state = capture ? fhl_pkg::FHL_HOLD : fhl_pkg::FHL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= fhl_pkg::FHL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The snapshot loads on the same edge that fills slot 0, so it never
  // describes any fault but the newest; one short register per field
  // keeps a missing enable visible field by field

  // Armature current at the fault, tenths of an ampere
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_armature_current_snap <= '0;
    end else if (capture) begin
      fault_armature_current_snap <= next_ia;
    end
  end

  // Armature voltage at the fault, volts
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_armature_voltage_snap <= '0;
    end else if (capture) begin
      fault_armature_voltage_snap <= next_va;
    end
  end

  // Motor speed at the fault, rpm
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_speed_snap <= '0;
    end else if (capture) begin
      fault_speed_snap <= next_spd;
    end
  end

  // Total speed reference at the fault, signed rpm
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_total_reference_snap <= '0;
    end else if (capture) begin
      fault_total_reference_snap <= next_ref;
    end
  end

  // Field current at the fault, tenths of an ampere
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_field_current_snap <= '0;
    end else if (capture) begin
      fault_field_current_snap <= next_if;
    end
  end

  // Digital input states, first input in bit 0, one means active
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_input_states_snap <= '0;
    end else if (capture) begin
      fault_input_states_snap <= digital_inputs_in;
    end
  end

  // Digital output states, first output in bit 0, one means active
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_output_states_snap <= '0;
    end else if (capture) begin
      fault_output_states_snap <= digital_outputs_in;
    end
  end

  // Public views of the newest and oldest entries; decoding them here
  // keeps the registers below to plain copies
  wire [9:0] view_newest_code;
  wire [9:0] view_oldest_code;
  wire [8:0] view_day_month; // Day high, month low
  wire [11:0] view_year;
  wire [10:0] view_time; // Hour high, minute low
  assign view_newest_code = slot_q[0].code;
  assign view_oldest_code = slot_q[`FHL_DEPTH-1].code;
  assign view_day_month = {slot_q[0].day, slot_q[0].month};
  assign view_year = slot_q[0].year;
  assign view_time = {slot_q[0].hour, slot_q[0].minute};

  // Fields of the slot picked by the keypad
  wire [9:0] sel_code;
  wire [4:0] sel_day;
  wire [3:0] sel_month;
  wire [11:0] sel_year;
  wire [4:0] sel_hour;
  wire [5:0] sel_minute;
  assign sel_code = sel_entry.code;
  assign sel_day = sel_entry.day;
  assign sel_month = sel_entry.month;
  assign sel_year = sel_entry.year;
  assign sel_hour = sel_entry.hour;
  assign sel_minute = sel_entry.minute;

  // Keypad view of the selected slot, one cycle behind read_slot; a
  // slot is only ever read here, never written
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      read_code <= '0;
      read_day <= '0;
      read_month <= '0;
      read_year <= '0;
      read_hour <= '0;
      read_minute <= '0;
    end else begin
      read_code <= sel_code;
      read_day <= sel_day;
      read_month <= sel_month;
      read_year <= sel_year;
      read_hour <= sel_hour;
      read_minute <= sel_minute;
    end
  end

  // Newest and oldest codes, one cycle behind the chain
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      newest_fault_code <= '0;
      oldest_fault_code <= '0;
    end else begin
      newest_fault_code <= view_newest_code;
      oldest_fault_code <= view_oldest_code;
    end
  end

  // Stamps of the newest fault, in step with its code
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      newest_fault_day_month <= '0;
      newest_fault_year <= '0;
      newest_fault_time <= '0;
    end else begin
      newest_fault_day_month <= view_day_month;
      newest_fault_year <= view_year;
      newest_fault_time <= view_time;
    end
  end

  // Record pulse: the hold state marks the edge after a capture, so the
  // pulse lines up with the newest views rather than with the snapshot
  wire in_hold;
  assign in_hold = (state == fhl_pkg::FHL_HOLD);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_recorded <= 1'b0;
    end else begin
      fault_recorded <= in_hold;
    end
  end

endmodule // fhl_logger

// >>> hw/fhl_consts.svh
// Constants for the fault history logger
`ifndef FHL_CONSTS_SVH
`define FHL_CONSTS_SVH
`define FHL_DEPTH 10
`define FHL_CODE_W 10
`define FHL_CODE_MAX 10'h3e7
`define FHL_DAY_W 5
`define FHL_DAY_MAX 5'h1f
`define FHL_MON_W 4
`define FHL_MON_MAX 4'hc
`define FHL_YEAR_W 12
`define FHL_YEAR_MAX 12'h833
`define FHL_HOUR_W 5
`define FHL_HOUR_MAX 5'h17
`define FHL_MIN_W 6
`define FHL_MIN_MAX 6'h3b
`define FHL_IA_W 16
`define FHL_IA_MAX 16'hc350
`define FHL_VA_W 11
`define FHL_VA_MAX 11'h7d0
`define FHL_SPD_W 14
`define FHL_SPD_MAX 14'h2710
`define FHL_REF_W 15
`define FHL_REF_MAX 15'sh2710
`define FHL_REF_MIN (-15'sh2710)
`define FHL_IF_W 10
`define FHL_IF_MAX 10'h258
`define FHL_DI_W 8
`define FHL_DO_W 5
`endif

// >>> hw/fhl_pkg.sv
// Types shared by the fault history logger files
package fhl_pkg;
  // One history entry: code plus its three stamps
  typedef struct packed {
    logic [9:0] code;
    logic [4:0] day;
    logic [3:0] month;
    logic [11:0] year;
    logic [4:0] hour;
    logic [5:0] minute;
  } fhl_entry_t;
  // Capture sequencer states
  typedef enum logic [1:0] {
    FHL_IDLE = 2'b01,
    FHL_HOLD = 2'b10
  } fhl_state_t;
endpackage

// >>> hw/fhl_stamp_if.sv
// Carrier for a clamped history entry between the logger modules
`timescale 1ns/1ns
interface fhl_stamp_if;
  fhl_pkg::fhl_entry_t raw; // Entry as offered by the fault source
  fhl_pkg::fhl_entry_t clean; // Entry with every field held in range
  modport src (output raw, input clean);
  modport chk (input raw, output clean);
endinterface

// >>> hw/fhl_clamp.sv
// Clamps an incoming fault code and its stamps into their legal ranges
`timescale 1ns/1ns
`include "fhl_consts.svh"
module fhl_clamp (
  fhl_stamp_if.chk st
);
  // Over-range values saturate so that stored fields never leave range
  assign st.clean.code = (st.raw.code > `FHL_CODE_MAX) ?
    `FHL_CODE_MAX : st.raw.code;
  assign st.clean.day = st.raw.day; // Five bits cannot pass 31
  assign st.clean.month = (st.raw.month > `FHL_MON_MAX) ?
    `FHL_MON_MAX : st.raw.month;
  assign st.clean.year = (st.raw.year > `FHL_YEAR_MAX) ?
    `FHL_YEAR_MAX : st.raw.year;
  assign st.clean.hour = (st.raw.hour > `FHL_HOUR_MAX) ?
    `FHL_HOUR_MAX : st.raw.hour;
  assign st.clean.minute = (st.raw.minute > `FHL_MIN_MAX) ?
    `FHL_MIN_MAX : st.raw.minute;
endmodule // fhl_clamp

// >>> hw/fhl_slot.sv
// One history slot: loads the entry from the newer neighbour on a shift
`timescale 1ns/1ns
module fhl_slot (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic shift,
  input wire fhl_pkg::fhl_entry_t newer,
  output fhl_pkg::fhl_entry_t held
);
  // Code and stamps move as one word, so they never part
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      held <= '0;
    end else if (shift) begin
      held <= newer;
    end
  end
endmodule // fhl_slot

// >>> dv/fhl_logger_props.sv
// Concurrent checks on the fault history logger top ports
`timescale 1ns/1ns
module fhl_logger_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic fault_strobe,
  input wire logic [9:0] fault_code_in,
  input wire logic [11:0] rtc_year,
  input wire logic [13:0] speed_in,
  input wire logic signed [14:0] total_reference_in,
  input wire logic [7:0] digital_inputs_in,
  input wire logic [4:0] digital_outputs_in,
  input wire logic [9:0] newest_fault_code,
  input wire logic [11:0] newest_fault_year,
  input wire logic [13:0] fault_speed_snap,
  input wire logic signed [14:0] fault_total_reference_snap,
  input wire logic [7:0] fault_input_states_snap,
  input wire logic [4:0] fault_output_states_snap,
  input wire logic fault_recorded
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A fault is taken at an edge; the public view lags it by two edges
  sequence s_take;
    fault_strobe;
  endsequence
  sequence s_seen;
    ##2 fault_recorded;
  endsequence
  property p_rec;
    s_take |-> s_seen;
  endproperty
  a_rec: assert property (p_rec) else $error("no record pulse");
  property p_quiet;
    !$past(fault_strobe, 2) |-> !fault_recorded && $stable(newest_fault_code);
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray change");
  property p_code;
    s_take and fault_code_in <= 10'h3e7
      |-> ##2 newest_fault_code == $past(fault_code_in, 2);
  endproperty
  a_code: assert property (p_code) else $error("code wrong");
  property p_sat;
    s_take and fault_code_in > 10'h3e7 |-> ##2 newest_fault_code == 10'h3e7;
  endproperty
  a_sat: assert property (p_sat) else $error("code over range");
  property p_year;
    s_take and rtc_year <= 12'h833
      |-> ##2 newest_fault_year == $past(rtc_year, 2);
  endproperty
  a_year: assert property (p_year) else $error("year wrong");
  property p_di;
    s_take |=> fault_input_states_snap == $past(digital_inputs_in);
  endproperty
  a_di: assert property (p_di) else $error("inputs snap wrong");
  property p_do;
    s_take |=> fault_output_states_snap == $past(digital_outputs_in);
  endproperty
  a_do: assert property (p_do) else $error("outputs snap wrong");
  property p_spd;
    s_take and speed_in <= 14'h2710 |=> fault_speed_snap == $past(speed_in);
  endproperty
  a_spd: assert property (p_spd) else $error("speed snap wrong");
  property p_ref;
    s_take |=> fault_total_reference_snap == $past(total_reference_in);
  endproperty
  a_ref: assert property (p_ref) else $error("ref snap wrong");
endmodule // fhl_logger_props
bind fhl_logger fhl_logger_props i_fhl_logger_props (.*);

// >>> dv/fhl_keypad.sv
// Operator keypad model: picks which history slot is on view
`timescale 1ns/1ns
module fhl_keypad (
  input wire logic ref_clk,
  input wire logic [3:0] want,
  output logic [3:0] read_slot
);
  initial read_slot = 4'h0;
  // Select moves just after an edge; the keypad has no write path at all
  always @(posedge ref_clk) begin
    read_slot <= want;
  end
endmodule // fhl_keypad

// >>> dv/fault_history_logger_tb_top.sv
// Self-checking bench for the fault history logger
`timescale 1ns/1ns
module fault_history_logger_tb_top;
  logic ref_clk = 0, reset = 1, fault_strobe = 0, fault_recorded;
  logic [9:0] fault_code_in = 0, field_current_in = 0, read_code;
  logic [9:0] newest_fault_code, oldest_fault_code, fault_field_current_snap;
  logic [4:0] rtc_day = 0, rtc_hour = 0, digital_outputs_in = 0, read_day;
  logic [4:0] read_hour, fault_output_states_snap;
  logic [3:0] rtc_month = 0, read_slot, want = 0, read_month;
  logic [11:0] rtc_year = 0, read_year, newest_fault_year;
  logic [5:0] rtc_minute = 0, read_minute;
  logic [15:0] armature_current_in = 0, fault_armature_current_snap;
  logic [10:0] armature_voltage_in = 0, fault_armature_voltage_snap;
  logic [10:0] newest_fault_time;
  logic [13:0] speed_in = 0, fault_speed_snap;
  logic signed [14:0] total_reference_in = 0, fault_total_reference_snap;
  logic [7:0] digital_inputs_in = 0, fault_input_states_snap;
  logic [8:0] newest_fault_day_month;
  logic [31:0] st = 32'h42e0; // Random state
  logic [127:0] expq[$]; // Expected views and snapshot per fault
  logic [41:0] hist[10] = '{default: 42'h0}; // Code and stamps per slot
  logic [78:0] snap_d; // Snapshot outputs, one edge late
  int bad_count = 0, n_compared = 0;
  fhl_logger i_fhl_logger (.*);
  fhl_keypad i_fhl_keypad (.ref_clk, .want, .read_slot);
  initial forever #50 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  // One fault per call; back-to-back calls keep the strobe high.
  // Stamps other than the year (drawn below 2100) and measured values other than the total reference (drawn within 10000 rpm) span
  // their whole port width, so values beyond the legal maxima are offered and must saturate
  task automatic strobe(input logic [9:0] c, input logic [11:0] y);
    logic [9:0] ec, f;
    logic [11:0] ey;
    logic [13:0] s;
    logic [7:0] d;
    logic [4:0] o, dy, h;
    logic [3:0] m;
    logic [5:0] mi;
    logic [15:0] a;
    logic [10:0] v;
    logic signed [14:0] t;
    ec = (c > 10'h3e7) ? 10'h3e7 : c;
    ey = (y > 12'h833) ? 12'h833 : y;
    s = 14'(xs());
    d = 8'(xs());
    o = 5'(xs());
    t = 15'(int'(xs() % 20001) - 10000);
    dy = 5'(xs());
    m = 4'(xs());
    h = 5'(xs());
    mi = 6'(xs());
    a = 16'(xs());
    v = 11'(xs());
    f = 10'(xs());
    @(posedge ref_clk);
    fault_strobe <= 1'b1;
    fault_code_in <= c;
    rtc_year <= y;
    speed_in <= s;
    digital_inputs_in <= d;
    digital_outputs_in <= o;
    total_reference_in <= t;
    rtc_day <= dy;
    rtc_month <= m;
    rtc_hour <= h;
    rtc_minute <= mi;
    armature_current_in <= a;
    armature_voltage_in <= v;
    field_current_in <= f;
    // Expected values stop at the legal maxima
    m = (m > 4'hc) ? 4'hc : m;
    h = (h > 5'h17) ? 5'h17 : h;
    mi = (mi > 6'h3b) ? 6'h3b : mi;
    a = (a > 16'hc350) ? 16'hc350 : a;
    v = (v > 11'h7d0) ? 11'h7d0 : v;
    f = (f > 10'h258) ? 10'h258 : f;
    s = (s > 14'h2710) ? 14'h2710 : s;
    expq.push_back(128'({ec, ey, dy, m, h, mi, a, v, f, s, d, o, t}));
    for (int i = 9; i > 0; i--) hist[i] = hist[i-1];
    hist[0] = {ec, ey, dy, m, h, mi};
  endtask
  // Snapshot copy one edge late, so it lines up with the record pulse
  always @(posedge ref_clk) begin
    snap_d <= {fault_armature_current_snap, fault_armature_voltage_snap,
      fault_field_current_snap, fault_speed_snap, fault_input_states_snap,
      fault_output_states_snap, fault_total_reference_snap};
  end
  // Monitor: each record pulse retires the oldest expected fault
  always @(negedge ref_clk) begin : mon
    logic [127:0] e;
    logic [41:0] v;
    if (fault_recorded === 1'b1) begin
      if (expq.size() == 0) begin
        check(128'h1, 128'h0);
      end else begin
        e = expq.pop_front();
        v = {newest_fault_code, newest_fault_year, newest_fault_day_month,
          newest_fault_time};
        check(128'(v), 128'(e[120:79]));
        check(128'(snap_d), 128'(e[78:0]));
      end
    end
  end
  task automatic final_report();
    $display("mismatches %0d, compares %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check(128'(newest_fault_code), 128'h0);
    repeat (12) strobe(10'(xs() % 1000), 12'(xs() % 2100));
    strobe(10'h3ff, 12'hfff);
    @(posedge ref_clk);
    fault_strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Walk every slot from the keypad side, one extra slot past the end
    for (int k = 0; k < 11; k++) begin
      want <= 4'(k);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check(128'({read_code, read_year, read_day, read_month, read_hour,
        read_minute}), 128'(hist[k > 9 ? 9 : k]));
    end
    check(128'(oldest_fault_code), 128'(hist[9][41:32]));
    check(128'(expq.size()), 128'h0);
    final_report();
  end
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule // fault_history_logger_tb_top
